// ===== src/sec_pkg.sv
// Purpose: constants shared by the system exception control block
// Assumes: 32-bit avalon data, byte addresses on the bus
// Notes: handler state bits keep their register positions
package sec_pkg;
    // register byte addresses
    localparam logic [31:0] ADR_RESET_CTRL = 32'he000ed0c;
    localparam logic [31:0] ADR_PRIO_FAULT = 32'he000ed18;
    localparam logic [31:0] ADR_PRIO_SVC = 32'he000ed1c;
    localparam logic [31:0] ADR_PRIO_TICK = 32'he000ed20;
    localparam logic [31:0] ADR_HANDLER = 32'he000ed24;
    localparam logic [31:0] ADR_EVT_STATUS = 32'he000ed40;
    localparam logic [31:0] ADR_EVT_ENABLE = 32'he000ed44;
    localparam logic [31:0] ADR_EVT_CLEAR = 32'he000ed48;

    // interrupt and reset control fields
    localparam int BIT_LOC_RST = 0;
    localparam int BIT_CLR_ACT = 1;
    localparam int BIT_RST_REQ = 2;
    localparam int PRIGROUP_LSB = 8;
    localparam int PRIGROUP_W = 3;
    localparam int BIT_ENDIAN = 15;
    localparam int KEY_LSB = 16;
    localparam logic [15:0] KEY_WRITE = 16'h05fa;
    localparam logic [15:0] KEY_READ = 16'hfa05;
    localparam logic [PRIGROUP_W-1:0] PRIGROUP_RST = 3'h0;

    // priority words: four byte fields, top three bits implemented
    localparam int PRIO_WORDS = 3;
    localparam int PRIO_W = 3;
    localparam int PRIO_LSB = 5;
    localparam logic [31:0] PRIO_MASK = 32'he0e0e0e0;
    localparam logic [PRIO_W-1:0] PRIO_RST = 3'h0;

    // handler control and state layout
    localparam int HS_W = 19;
    localparam logic [HS_W-1:0] HS_MASK = 19'h7fd8b;
    localparam logic [HS_W-1:0] HS_ACTIVE = 19'h00d8b;
    localparam logic [HS_W-1:0] HS_RST = 19'h00000;

    // event status bits
    localparam int EVT_W = 4;
    localparam int EVT_RST_REQ = 0;
    localparam int EVT_CLR_ACT = 1;
    localparam int EVT_LOC_RST = 2;
    localparam int EVT_KEY_BAD = 3;
    localparam logic [EVT_W-1:0] EVT_RST = 4'h0;
endpackage : sec_pkg

// ===== src/sec_exception_ctrl.sv
// Purpose: system exception control registers on an avalon-mm slave
// Assumes: one clock; rstn is the chip warm reset
// Notes: answers every access one cycle after it appears
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module sec_exception_ctrl #(
    parameter logic BIG_ENDIAN = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [31:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [sec_pkg::HS_W-1:0] hw_state_set,
    input wire logic [sec_pkg::HS_W-1:0] hw_state_clr,
    output logic system_reset_request,
    output logic clear_active_pulse,
    output logic local_reset_pulse,
    output logic [sec_pkg::HS_W-1:0] handler_state,
    output logic [sec_pkg::PRIGROUP_W-1:0] priority_grouping,
    output logic [4*sec_pkg::PRIO_WORDS*sec_pkg::PRIO_W-1:0] priority_levels,
    output logic irq
);
    import sec_pkg::*;

    localparam int NPRI = 4 * PRIO_WORDS;

    logic [PRIO_W-1:0] prio [NPRI];
    logic [EVT_W-1:0] evt_status;
    logic [EVT_W-1:0] evt_enable;
    logic [EVT_W-1:0] next_status;
    logic [HS_W-1:0] next_hs;
    logic [31:0] lane;
    logic [31:0] rd_value;
    logic wr_go;
    logic rd_take;
    logic sel_rst;
    logic key_ok;
    logic ctl_wr;
    logic do_clr_act;
    logic do_loc_rst;
    logic do_rst_req;
    logic [EVT_W-1:0] evt_hit;
    logic [1:0] prio_word;

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    // a write takes effect on the edge where waitrequest is seen low
    assign wr_go = write && !waitrequest;
    assign rd_take = read && waitrequest;
    assign lane = lane_mask(byteenable);
    // word index of the priority words, kept at two bits on purpose
    assign prio_word = address[3:2] - ADR_PRIO_FAULT[3:2];
    assign sel_rst = address == ADR_RESET_CTRL;
    assign key_ok = (byteenable[3:2] == 2'b11) &&
                    (writedata[31:KEY_LSB] == KEY_WRITE);
    assign ctl_wr = wr_go && sel_rst && key_ok;
    assign do_rst_req = ctl_wr && byteenable[0] &&
                        writedata[BIT_RST_REQ];
    assign do_clr_act = ctl_wr && byteenable[0] &&
                        writedata[BIT_CLR_ACT];
    assign do_loc_rst = ctl_wr && byteenable[0] &&
                        writedata[BIT_LOC_RST];

    // bus handshake: one wait cycle, then a one-cycle answer
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            waitrequest <= 1'b1;
        end else if (!waitrequest) begin
            waitrequest <= 1'b1;
        end else if (read || write) begin
            waitrequest <= 1'b0;
        end
    end

    // read mux; unmapped addresses and write-only words read zero
    always_comb begin
        rd_value = 32'h0;
        case (address)
            ADR_RESET_CTRL: begin
                rd_value[31:KEY_LSB] = KEY_READ;
                rd_value[BIT_ENDIAN] = BIG_ENDIAN;
                rd_value[PRIGROUP_LSB +: PRIGROUP_W] = priority_grouping;
                rd_value[BIT_RST_REQ] = system_reset_request;
                // clear-active and local reset bits always read zero
            end
            ADR_PRIO_FAULT, ADR_PRIO_SVC, ADR_PRIO_TICK: begin
                for (int b = 0; b < 4; b++) begin
                    rd_value[8*b+PRIO_LSB +: PRIO_W] =
                        prio[4*prio_word+b];
                end
            end
            ADR_HANDLER: begin
                rd_value[HS_W-1:0] = handler_state & HS_MASK;
            end
            ADR_EVT_STATUS: begin
                rd_value[EVT_W-1:0] = evt_status;
            end
            ADR_EVT_ENABLE: begin
                rd_value[EVT_W-1:0] = evt_enable;
            end
            default: begin
                rd_value = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            readdata <= 32'h0;
        end else if (rd_take) begin
            readdata <= rd_value;
        end
    end

    // reset request holds until the warm reset it causes clears it
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            system_reset_request <= 1'b0;
        end else if (do_rst_req) begin
            system_reset_request <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            clear_active_pulse <= 1'b0;
            local_reset_pulse <= 1'b0;
        end else begin
            clear_active_pulse <= do_clr_act;
            local_reset_pulse <= do_loc_rst;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            priority_grouping <= PRIGROUP_RST;
        end else if (do_loc_rst) begin
            priority_grouping <= PRIGROUP_RST;
        end else if (ctl_wr && byteenable[1]) begin
            priority_grouping <= writedata[PRIGROUP_LSB +: PRIGROUP_W];
        end
    end

    // priority bytes; low five bits of each byte are not stored
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NPRI; i++) begin
                prio[i] <= PRIO_RST;
            end
        end else if (do_loc_rst) begin
            for (int i = 0; i < NPRI; i++) begin
                prio[i] <= PRIO_RST;
            end
        end else if (wr_go && (address == ADR_PRIO_FAULT ||
                     address == ADR_PRIO_SVC ||
                     address == ADR_PRIO_TICK)) begin
            for (int b = 0; b < 4; b++) begin
                if (byteenable[b]) begin
                    prio[4*prio_word+b] <=
                        writedata[8*b+PRIO_LSB +: PRIO_W];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NPRI; i++) begin
            priority_levels[PRIO_W*i +: PRIO_W] = prio[i];
        end
    end

    // handler state: software edit, then wipe, then core events win
    always_comb begin
        next_hs = handler_state;
        if (wr_go && address == ADR_HANDLER) begin
            next_hs = (handler_state & ~(lane[HS_W-1:0] & HS_MASK)) |
                      (writedata[HS_W-1:0] & lane[HS_W-1:0] &
                       HS_MASK);
        end
        if (do_clr_act) begin
            next_hs = next_hs & ~HS_ACTIVE;
        end
        if (do_loc_rst) begin
            next_hs = HS_RST;
        end
        next_hs = ((next_hs & ~hw_state_clr) | hw_state_set) & HS_MASK;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            handler_state <= HS_RST;
        end else begin
            handler_state <= next_hs;
        end
    end

    // sticky events; a new event beats a clear in the same cycle
    always_comb begin
        evt_hit = '0;
        evt_hit[EVT_RST_REQ] = do_rst_req;
        evt_hit[EVT_CLR_ACT] = do_clr_act;
        evt_hit[EVT_LOC_RST] = do_loc_rst;
        evt_hit[EVT_KEY_BAD] = wr_go && sel_rst && !key_ok;
        next_status = evt_status;
        if (wr_go && address == ADR_EVT_CLEAR && byteenable[0]) begin
            next_status = evt_status & ~writedata[EVT_W-1:0];
        end
        next_status = next_status | evt_hit;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            evt_status <= EVT_RST;
        end else begin
            evt_status <= next_status;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            evt_enable <= EVT_RST;
        end else if (wr_go && address == ADR_EVT_ENABLE && byteenable[0]) begin
            evt_enable <= writedata[EVT_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & evt_enable);
        end
    end

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    a_bus_answer: assert property ((read || write) && waitrequest |=>
        !waitrequest ##1 waitrequest)
        else $error("access not answered after one wait cycle");
    a_reset_request_set: assert property (do_rst_req |=>
        system_reset_request [*3])
        else $error("reset request not raised by control write");
    a_reset_request_hold: assert property (
        system_reset_request |=> system_reset_request)
        else $error("reset request dropped without warm reset");
    a_key_gate: assert property (wr_go && sel_rst && !key_ok |=>
        $stable(system_reset_request) && !clear_active_pulse &&
        !local_reset_pulse && evt_status[EVT_KEY_BAD])
        else $error("control write without key took effect");
    a_clear_pulse: assert property (do_clr_act |=>
        clear_active_pulse ##1 !clear_active_pulse)
        else $error("clear-active did not self-clear after one cycle");
    a_clear_wipes: assert property (clear_active_pulse |->
        (handler_state & HS_ACTIVE & ~$past(hw_state_set)) == '0)
        else $error("active flags survived clear-active");
    a_ctrl_readback: assert property (rd_take && sel_rst |=>
        readdata[31:KEY_LSB] == KEY_READ && readdata[1:0] == 2'b00 &&
        readdata[BIT_ENDIAN] == BIG_ENDIAN)
        else $error("control register read back wrong");
    a_prio_unused: assert property (rd_take && (address == ADR_PRIO_FAULT ||
        address == ADR_PRIO_SVC || address == ADR_PRIO_TICK) |=>
        (readdata & ~PRIO_MASK) == 32'h0)
        else $error("unimplemented priority bits read nonzero");
    a_prio_fault_word: assert property (wr_go &&
        address == ADR_PRIO_FAULT && byteenable == 4'hf && !do_loc_rst |=>
        priority_levels[4*PRIO_W-1:0] ==
        {$past(writedata[31:29]), $past(writedata[23:21]),
         $past(writedata[15:13]), $past(writedata[7:5])})
        else $error("fault priority fields not stored");
    a_handler_reserved: assert property (
        (handler_state & ~HS_MASK) == '0 ##1
        (!$past(rd_take) || $past(address) != ADR_HANDLER ||
         (readdata[31:HS_W] == '0)))
        else $error("reserved handler bits nonzero");
    a_handler_write: assert property (wr_go && address == ADR_HANDLER &&
        byteenable == 4'hf && !do_loc_rst && hw_state_set == '0 &&
        hw_state_clr == '0 |=> handler_state ==
        ($past(writedata[HS_W-1:0]) & HS_MASK))
        else $error("handler write not applied");

    // register side effects and interrupt level
    a_request_source: assert property (
        $rose(system_reset_request) |-> $past(do_rst_req))
        else $error("reset request rose without a keyed write");
    a_clear_keeps: assert property (do_clr_act && !do_loc_rst &&
        hw_state_set == '0 && hw_state_clr == '0 |=>
        (handler_state & ~HS_ACTIVE) ==
        ($past(handler_state) & ~HS_ACTIVE))
        else $error("clear-active touched enable or pending bits");
    a_local_wipe: assert property (do_loc_rst |=>
        handler_state == ($past(hw_state_set) & HS_MASK) &&
        priority_levels == '0 && priority_grouping == PRIGROUP_RST)
        else $error("local reset left handler or priority state");
    a_group_write: assert property (ctl_wr && byteenable[1] &&
        !do_loc_rst |=> priority_grouping ==
        $past(writedata[PRIGROUP_LSB +: PRIGROUP_W]))
        else $error("keyed grouping write not stored");
    a_event_sticky: assert property (
        !(wr_go && address == ADR_EVT_CLEAR) |=>
        (evt_status & $past(evt_status)) == $past(evt_status))
        else $error("event status bit dropped without a clear");
    a_enable_write: assert property (wr_go && byteenable[0] &&
        address == ADR_EVT_ENABLE |=>
        evt_enable == $past(writedata[EVT_W-1:0]))
        else $error("event enable write not stored");
    a_irq_level: assert property ($stable(evt_enable) |->
        irq == ((evt_status & evt_enable) != '0))
        else $error("interrupt does not follow enabled status");

    c_reset_request: cover property (do_rst_req ##1 system_reset_request);
    c_clear_active: cover property (clear_active_pulse);
    c_key_refused: cover property (wr_go && sel_rst && !key_ok);
    c_irq_raised: cover property (!irq ##1 irq);
    c_local_reset: cover property (do_loc_rst ##1 local_reset_pulse);
endmodule : sec_exception_ctrl
`default_nettype wire

// ===== verif/sec_core_model.sv
// Purpose: core and chip warm reset model facing the exception block
// Assumes: one clock; bench commands the core's handler events
// Notes: a reset request becomes a three cycle warm reset
`timescale 1ns/1ps
`default_nettype none
module sec_core_model (
    input wire logic clk_sys,
    input wire logic rstn_ext,
    input wire logic system_reset_request,
    input wire logic [sec_pkg::HS_W-1:0] core_set,
    input wire logic [sec_pkg::HS_W-1:0] core_clr,
    output logic rstn,
    output logic [sec_pkg::HS_W-1:0] hw_state_set,
    output logic [sec_pkg::HS_W-1:0] hw_state_clr
);
    import sec_pkg::*;
    logic [1:0] warm_cnt;
    always_ff @(posedge clk_sys or negedge rstn_ext) begin
        if (!rstn_ext) begin
            warm_cnt <= 2'h0;
        end else if (system_reset_request) begin
            warm_cnt <= 2'h3;
        end else if (warm_cnt != 2'h0) begin
            warm_cnt <= warm_cnt - 2'h1;
        end
    end
    assign rstn = rstn_ext && (warm_cnt == 2'h0);
    // core marks handlers active or idle as the bench commands, one cycle later
    always_ff @(posedge clk_sys or negedge rstn_ext) begin
        if (!rstn_ext) begin
            hw_state_set <= '0;
            hw_state_clr <= '0;
        end else begin
            hw_state_set <= core_set;
            hw_state_clr <= core_clr;
        end
    end
endmodule : sec_core_model
`default_nettype wire

// ===== verif/system_exception_control_tb.sv
// Purpose: self-checking bench for the system exception control block
// Assumes: avalon master with waitrequest, core model beside the block
// Notes: reset value reads first, then table of register cases, then reset and event cases
`timescale 1ns/1ps
`default_nettype none
module system_exception_control_tb;
    import sec_pkg::*;
    typedef struct {
        logic [31:0] adr;
        logic [31:0] wd;
        logic [3:0] be;
        logic [31:0] exp;
    } sec_row_t;
    logic clk_sys, rstn_ext, rstn, read, write, waitrequest, irq;
    logic system_reset_request, clear_active_pulse, local_reset_pulse;
    logic [31:0] address, writedata, readdata, rv;
    logic [3:0] byteenable;
    logic [HS_W-1:0] core_set, core_clr, hw_state_set, hw_state_clr;
    logic [HS_W-1:0] handler_state;
    logic [PRIGROUP_W-1:0] priority_grouping;
    logic [35:0] priority_levels;
    int errors, check_count;
    sec_row_t rows [9];

    sec_exception_ctrl dut_u (.clk_sys(clk_sys), .rstn(rstn),
        .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .hw_state_set(hw_state_set), .hw_state_clr(hw_state_clr),
        .system_reset_request(system_reset_request),
        .clear_active_pulse(clear_active_pulse),
        .local_reset_pulse(local_reset_pulse),
        .handler_state(handler_state),
        .priority_grouping(priority_grouping),
        .priority_levels(priority_levels), .irq(irq));
    sec_core_model core_u (.clk_sys(clk_sys), .rstn_ext(rstn_ext),
        .system_reset_request(system_reset_request), .core_set(core_set),
        .core_clr(core_clr), .rstn(rstn), .hw_state_set(hw_state_set),
        .hw_state_clr(hw_state_clr));

    task automatic test_done();
        if (errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input int wr, input logic [31:0] adr,
        input logic [31:0] wd, input logic [3:0] be = 4'hf);
        int n;
        @(posedge clk_sys);
        address <= adr;
        writedata <= wd;
        byteenable <= be;
        write <= (wr != 0);
        read <= (wr == 0);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rv = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0) begin
            errors++;
            test_done();
        end
    endtask : bus

    task automatic wait_rstn(input logic lvl);
        int n;
        n = 0;
        while (rstn !== lvl && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        if (rstn !== lvl) begin
            errors++;
            test_done();
        end
    endtask : wait_rstn

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial begin
        {read, write, address, writedata, byteenable} = '0;
        core_set = '0;
        core_clr = '0;
        errors = 0;
        check_count = 0;
        rows = '{
            '{ADR_PRIO_FAULT, 32'hffffffff, 4'hf, 32'he0e0e0e0},
            '{ADR_PRIO_FAULT, 32'h1f1f1f00, 4'hf, 32'h00000000},
            '{ADR_PRIO_SVC, 32'hffffffff, 4'hf, 32'he0e0e0e0},
            '{ADR_PRIO_SVC, 32'h00000000, 4'h3, 32'he0e00000},
            '{ADR_PRIO_TICK, 32'h12345678, 4'hf, 32'h00204060},
            '{ADR_RESET_CTRL, 32'h05fa0300, 4'hf, 32'hfa050300},
            '{ADR_RESET_CTRL, 32'h05fa0001, 4'h1, 32'hfa050300},
            '{ADR_HANDLER, 32'hffffffff, 4'hf, 32'h0007fd8b},
            '{32'he000ed30, 32'hffffffff, 4'hf, 32'h00000000}};
        rstn_ext = 1'b0;
        repeat (8) @(posedge clk_sys);
        rstn_ext <= 1'b1;
        bus(0, ADR_PRIO_FAULT, 32'h0);
        chk("prio rst", rv, 32'h0);
        bus(0, ADR_HANDLER, 32'h0);
        chk("hs rst", rv, 32'h0);
        bus(0, ADR_RESET_CTRL, 32'h0);
        chk("ctrl rst", rv, 32'hfa050000);
        foreach (rows[i]) begin
            bus(1, rows[i].adr, rows[i].wd, rows[i].be);
            bus(0, rows[i].adr, 32'h0);
            chk("row", rv, rows[i].exp);
        end
        chk("levels", {20'h0, priority_levels[35:24]}, 32'h053);
        chk("group", {29'h0, priority_grouping}, 32'h3);
        bus(1, ADR_RESET_CTRL, 32'h05fa0302);
        #1 chk("clr pulse", {31'h0, clear_active_pulse}, 32'h1);
        bus(0, ADR_HANDLER, 32'h0);
        chk("clr act", rv, 32'h0007f000);
        bus(0, ADR_RESET_CTRL, 32'h0);
        chk("clr bit", rv, 32'hfa050300);
        core_set <= 19'h00800;
        core_clr <= 19'h00800;
        @(posedge clk_sys);
        core_set <= '0;
        core_clr <= '0;
        bus(0, ADR_HANDLER, 32'h0);
        chk("core set", rv, 32'h0007f800);
        chk("hs port", {13'h0, handler_state}, 32'h0007f800);
        bus(1, ADR_EVT_CLEAR, 32'hf);
        bus(1, ADR_EVT_ENABLE, 32'h8);
        bus(1, ADR_RESET_CTRL, 32'h00000001);
        #1 chk("key pulse", {31'h0, local_reset_pulse}, 32'h0);
        bus(0, ADR_EVT_STATUS, 32'h0);
        chk("bad key", rv, 32'h8);
        chk("irq on", {31'h0, irq}, 32'h1);
        bus(1, ADR_EVT_ENABLE, 32'h0);
        bus(0, ADR_EVT_STATUS, 32'h0);
        chk("irq mask", {31'h0, irq}, 32'h0);
        bus(1, ADR_EVT_ENABLE, 32'h8);
        bus(1, ADR_EVT_CLEAR, 32'h8);
        bus(0, ADR_EVT_STATUS, 32'h0);
        chk("evt clr", {rv[31:1], irq}, 32'h0);
        bus(1, ADR_RESET_CTRL, 32'h05fa0001);
        #1 chk("loc pulse", {31'h0, local_reset_pulse}, 32'h1);
        bus(0, ADR_PRIO_SVC, 32'h0);
        chk("loc prio", rv, 32'h0);
        bus(0, ADR_HANDLER, 32'h0);
        chk("loc hs", rv, 32'h0);
        bus(0, ADR_RESET_CTRL, 32'h0);
        chk("loc bit", rv, 32'hfa050000);
        bus(1, ADR_RESET_CTRL, 32'h05fa0004);
        #1 chk("rst req", {31'h0, system_reset_request}, 32'h1);
        wait_rstn(1'b0);
        wait_rstn(1'b1);
        chk("req gone", {31'h0, system_reset_request}, 32'h0);
        bus(0, ADR_RESET_CTRL, 32'h0);
        chk("req bit", rv, 32'hfa050000);
        test_done();
    end
endmodule : system_exception_control_tb
`default_nettype wire
